// file: pkg/lpx_pkg.sv
/*
 * lpx_pkg: shared constants for the panel pixel link, 7:1 lane framing.
 * assumes: both ends run on one 40 MHz reference clock.
 */
package lpx_pkg;
    // ------------------------------------------------------------
    // link framing
    // ------------------------------------------------------------
    localparam int LPX_SLOTS = 7;
    localparam int LPX_LANES = 4;
    localparam int LPX_CLK_DIV = 2;
    localparam logic [2:0] LPX_SLOT_LAST = 3'h6;
    // clock lane pattern over the seven slots (high 2, low 3, high 2)
    localparam logic [6:0] LPX_CLK_PATTERN = 7'h63;
    // ------------------------------------------------------------
    // bit slot positions inside a lane word, slot 0 sent first
    // ------------------------------------------------------------
    localparam int LPX_L2_HS = 4;
    localparam int LPX_L2_VS = 5;
    localparam int LPX_L2_DE = 6;
    localparam int LPX_L3_RSV = 6;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] LPX_RGB_RST = 24'h000000;
    localparam logic [6:0] LPX_WORD_RST = 7'h00;
    // ------------------------------------------------------------
    // frame timing, 800x600 at 60 Hz
    // ------------------------------------------------------------
    localparam int LPX_H_ACTIVE = 800;
    localparam int LPX_H_TOTAL = 1056;
    localparam int LPX_V_ACTIVE = 600;
    localparam int LPX_V_TOTAL = 628;
    localparam int LPX_FRAME_HZ = 60;
endpackage

// file: pkg/lpx_link_if.sv
/*
 * lpx_link_if: the four data lanes and the clock lane between source
 * and panel. assumes: single-ended stand-ins for differential pairs.
 */
`timescale 1ns/1ps
interface lpx_link_if;
    logic lvds_clock_lane;
    logic [3:0] lvds_data_lane;
    modport source (output lvds_clock_lane, output lvds_data_lane);
    modport panel (input lvds_clock_lane, input lvds_data_lane);
endinterface

// file: logic/lpx_panel_rx.sv
/*
 * lpx_panel_rx: panel end of the pixel link; deserialises four lanes,
 * unpacks colour and syncs, applies depth select, passes scan select out.
 * assumes: clock lane is slow relative to ref_clk_i (sampled, edges found).
 */
`timescale 1ns/1ps
module lpx_panel_rx
    import lpx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    lpx_link_if.panel link,
    input wire logic color_depth_select_i,
    input wire logic reverse_scan_select_i,
    output logic [7:0] red_o,
    output logic [7:0] green_o,
    output logic [7:0] blue_o,
    output logic line_sync_o,
    output logic frame_sync_o,
    output logic pixel_valid_strobe_o,
    output logic reverse_scan_o,
    output logic eight_bit_o
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic clk_prev_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end
        else
        begin
            sync1_r <= {color_depth_select_i, reverse_scan_select_i,
                        link.lvds_data_lane[3], link.lvds_data_lane[2],
                        link.lvds_data_lane[1], link.lvds_data_lane[0]};
            sync2_r <= sync1_r;
        end
    end
    // clock lane gets its own pair so its edges can be found
    logic clk_s1_r;
    logic clk_s2_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_prev_r <= 1'b0;
        end
        else
        begin
            clk_s1_r <= link.lvds_clock_lane;
            clk_s2_r <= clk_s1_r;
            clk_prev_r <= clk_s2_r;
        end
    end
    // ------------------------------------------------------------
    // slot capture
    // ------------------------------------------------------------
    // each slot is one clock-lane period; sampling on the rising edge
    // lands mid-slot since the source changes data on falling edges
    wire slot_edge = clk_s2_r & ~clk_prev_r;
    // no pattern lock: the slot counter runs from reset, so both ends
    // must leave reset together or words arrive rotated
    logic [2:0] slot_r;
    wire slot_last = slot_r == LPX_SLOT_LAST;
    wire [2:0] slot_nxt = slot_last ? 3'h0 : slot_r + 3'h1;
    wire word_done = slot_edge && slot_last;
    wire word_start = slot_edge && slot_r == 3'h0;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            slot_r <= 3'h0;
        end
        else if (slot_edge)
        begin
            slot_r <= slot_nxt;
        end
    end
    // one shifter per lane; the word is read with the newest slot
    // still in flight so no extra cycle is lost
    logic [6:0] sh_r [LPX_LANES];
    logic [6:0] word_w [LPX_LANES];
    genvar ln;
    generate
        for (ln = 0; ln < LPX_LANES; ln++)
        begin : g_lane
            always_ff @(posedge ref_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    sh_r[ln] <= LPX_WORD_RST;
                end
                else if (slot_edge)
                begin
                    // slot k lands in bit k, so slot 0 ends as bit 0
                    sh_r[ln] <= {sync2_r[ln], sh_r[ln][6:1]};
                end
            end
            assign word_w[ln] = {sync2_r[ln], sh_r[ln][6:1]};
        end
    endgenerate
    // mode is held per word so a select that moves mid-word cannot
    // split one pixel between two depths
    logic word_eight_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            word_eight_r <= 1'b0;
        end
        else if (word_start)
        begin
            word_eight_r <= sync2_r[5];
        end
    end
    // ------------------------------------------------------------
    // lane unpack
    // ------------------------------------------------------------
    wire [6:0] w0 = word_w[0];
    wire [6:0] w1 = word_w[1];
    wire [6:0] w2 = word_w[2];
    wire [6:0] w3 = word_w[3];
    wire eight = word_eight_r;
    wire [5:0] r6 = w0[5:0];
    wire [5:0] g6 = {w1[4:0], w0[6]};
    wire [5:0] b6 = {w2[3:0], w1[6:5]};
    // lane 3 ignored in six-bit mode so a floating lane is harmless
    wire [1:0] r_hi = eight ? w3[1:0] : 2'h0;
    wire [1:0] g_hi = eight ? w3[3:2] : 2'h0;
    wire [1:0] b_hi = eight ? w3[5:4] : 2'h0;
    // six-bit data occupies the top bits so bit 5 stays MSB
    wire [7:0] r8 = eight ? {r_hi, r6} : {r6, 2'h0};
    wire [7:0] g8 = eight ? {g_hi, g6} : {g6, 2'h0};
    wire [7:0] b8 = eight ? {b_hi, b6} : {b6, 2'h0};
    wire de = w2[LPX_L2_DE];
    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reverse_scan_o <= 1'b0;
            eight_bit_o <= 1'b0;
        end
        else
        begin
            reverse_scan_o <= sync2_r[4];
            eight_bit_o <= sync2_r[5];
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            line_sync_o <= 1'b0;
            frame_sync_o <= 1'b0;
            pixel_valid_strobe_o <= 1'b0;
        end
        else
        begin
            pixel_valid_strobe_o <= word_done & de;
            if (word_done)
            begin
                line_sync_o <= w2[LPX_L2_HS];
                frame_sync_o <= w2[LPX_L2_VS];
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            {red_o, green_o, blue_o} <= LPX_RGB_RST;
        end
        else if (word_done && de)
        begin
            red_o <= r8;
            green_o <= g8;
            blue_o <= b8;
        end
    end
endmodule // lpx_panel_rx

// file: logic/lpx_source_tx.sv
/*
 * lpx_source_tx: source end of the pixel link; packs a pixel into four
 * seven-slot lane words and drives clock lane from a divider.
 * assumes: user holds pixel inputs until word_taken_o pulses.
 */
`timescale 1ns/1ps
module lpx_source_tx
    import lpx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    lpx_link_if.source link,
    input wire logic link_enable_i,
    input wire logic eight_bit_i,
    input wire logic [7:0] red_i,
    input wire logic [7:0] green_i,
    input wire logic [7:0] blue_i,
    input wire logic line_sync_i,
    input wire logic frame_sync_i,
    input wire logic pixel_valid_strobe_i,
    output logic word_taken_o
);
    logic [1:0] div_r;
    logic [2:0] slot_r;
    logic [6:0] w0_r, w1_r, w2_r, w3_r;
    logic clk_r;
    logic [3:0] data_r;
    wire tick = div_r == 2'(LPX_CLK_DIV - 1);
    wire last = slot_r == LPX_SLOT_LAST;
    wire [2:0] slot_nxt = slot_r + 3'h1;
    // lane words, slot 0 is bit 0
    wire [6:0] n0 = {green_i[0], red_i[5:0]};
    wire [6:0] n1 = {blue_i[1:0], green_i[5:1]};
    wire [6:0] n2 = {pixel_valid_strobe_i, frame_sync_i, line_sync_i,
                     blue_i[5:2]};
    // lane 3 idles low in six-bit mode
    wire [6:0] n3 = eight_bit_i ? {1'b0, blue_i[7:6], green_i[7:6],
                                   red_i[7:6]} : 7'h00;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div_r <= 2'h0;
            slot_r <= 3'h0;
            {w0_r, w1_r, w2_r, w3_r} <= 28'h0000000;
            clk_r <= 1'b0;
            data_r <= 4'h0;
            word_taken_o <= 1'b0;
        end
        else
        begin
            word_taken_o <= 1'b0;
            // outputs low while disabled, as when unpowered
            if (!link_enable_i)
            begin
                div_r <= 2'h0;
                slot_r <= 3'h0;
                clk_r <= 1'b0;
                data_r <= 4'h0;
            end
            else if (tick)
            begin
                div_r <= 2'h0;
                clk_r <= ~clk_r;
                if (clk_r) // falling edge: next slot
                begin
                    slot_r <= last ? 3'h0 : slot_nxt;
                    // one take per word, at the wrap to slot 0
                    if (last)
                    begin
                        w0_r <= n0;
                        w1_r <= n1;
                        w2_r <= n2;
                        w3_r <= n3;
                        word_taken_o <= 1'b1;
                        data_r <= {n3[0], n2[0], n1[0], n0[0]};
                    end
                    else
                    begin
                        data_r <= {w3_r[slot_nxt], w2_r[slot_nxt],
                                   w1_r[slot_nxt], w0_r[slot_nxt]};
                    end
                end
            end
            else
            begin
                div_r <= div_r + 2'h1;
            end
        end
    end
    assign link.lvds_clock_lane = clk_r;
    assign link.lvds_data_lane = data_r;
endmodule // lpx_source_tx

// file: verif/lpx_link_checker.sv
/* lpx_link_checker: assertions on the clock lane and both ends' ports.
   assumes: one ref clock domain; instantiated beside the link by the
   bench, with every pin tied by name. */
`timescale 1ns/1ps
module lpx_link_checker
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic lvds_clock_lane,
    input wire logic color_depth_select_i,
    input wire logic reverse_scan_select_i,
    input wire logic [7:0] red_o,
    input wire logic [7:0] green_o,
    input wire logic [7:0] blue_o,
    input wire logic pixel_valid_strobe_o,
    input wire logic reverse_scan_o,
    input wire logic eight_bit_o,
    input wire logic word_taken_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // seven slots of four cycles per word, so takes sit 28 cycles apart; the check wants 8 quiet cycles between
    sequence word_gap;
        !word_taken_o [*8];
    endsequence
    strobe_pulse_a: assert property (
        pixel_valid_strobe_o |=> !pixel_valid_strobe_o)
        else $error("valid strobe held past one cycle");
    word_pace_a: assert property (
        word_taken_o |=> word_gap ##[1:60] word_taken_o)
        else $error("word take spacing off");
    slot_hold_a: assert property (
        $changed(lvds_clock_lane) |=> $stable(lvds_clock_lane))
        else $error("clock lane toggled on consecutive cycles");
    clock_live_a: assert property (
        $changed(lvds_clock_lane) |-> ##[1:8] $changed(lvds_clock_lane))
        else $error("clock lane stopped");
    depth_follow_a: assert property (
        $changed(color_depth_select_i) |->
        ##[1:3] (eight_bit_o == color_depth_select_i))
        else $error("depth mode did not follow select");
    scan_follow_a: assert property (
        $changed(reverse_scan_select_i) |->
        ##[1:3] (reverse_scan_o == reverse_scan_select_i))
        else $error("scan mode did not follow select");
    colour_gate_a: assert property (
        $changed({red_o, green_o, blue_o}) |-> pixel_valid_strobe_o)
        else $error("colour changed without valid strobe");
    six_bit_a: assert property (
        pixel_valid_strobe_o && !eight_bit_o |->
        {red_o[1:0], green_o[1:0], blue_o[1:0]} == 6'h00)
        else $error("six-bit colour not left aligned");
endmodule // lpx_link_checker

// file: verif/lvds_panel_pixel_input_bench.sv
/* lvds_panel_pixel_input_bench: source end and panel end joined by the
   link; random pixels plus corner patterns, checked through a queue.
   assumes: both ends share ref clock and reset. */
`timescale 1ns/1ps
module lvds_panel_pixel_input_bench;
    logic ref_clk, rst_b, eight_bit, scan_sel, line_sync, frame_sync, de;
    logic [7:0] red, green, blue, rx_red, rx_green, rx_blue;
    logic rx_hs, rx_vs, rx_de, rx_rev, rx_eight, taken;
    logic [27:0] exp_word;
    logic [31:0] rnd;
    logic [27:0] q[$];
    int miscompares, check_count, seed;
    lpx_link_if lpx_link_if_i();
    lpx_source_tx lpx_source_tx_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .link(lpx_link_if_i), .link_enable_i(1'b1),
        .eight_bit_i(eight_bit), .red_i(red), .green_i(green),
        .blue_i(blue), .line_sync_i(line_sync), .frame_sync_i(frame_sync),
        .pixel_valid_strobe_i(de), .word_taken_o(taken));
    lpx_panel_rx lpx_panel_rx_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .link(lpx_link_if_i), .color_depth_select_i(eight_bit),
        .reverse_scan_select_i(scan_sel), .red_o(rx_red),
        .green_o(rx_green), .blue_o(rx_blue), .line_sync_o(rx_hs),
        .frame_sync_o(rx_vs), .pixel_valid_strobe_o(rx_de),
        .reverse_scan_o(rx_rev), .eight_bit_o(rx_eight));
    lpx_link_checker lpx_link_checker_i (.ref_clk_i(ref_clk),
        .rst_b_i(rst_b), .lvds_clock_lane(lpx_link_if_i.lvds_clock_lane),
        .color_depth_select_i(eight_bit), .reverse_scan_select_i(scan_sel),
        .red_o(rx_red), .green_o(rx_green), .blue_o(rx_blue),
        .pixel_valid_strobe_o(rx_de), .reverse_scan_o(rx_rev),
        .eight_bit_o(rx_eight), .word_taken_o(taken));
    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // six-bit pixels land in the upper bits of the eight-bit outputs
    function automatic logic [7:0] exp_colour(input logic [7:0] v,
                                              input logic m8);
        return m8 ? v : {v[5:0], 2'h0};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // holds the pixel until the source takes it; bounded wait
    task automatic send(input logic [23:0] rgb, input logic v,
                        input logic [1:0] sy);
        int n;
        {red, green, blue} <= rgb;
        de <= v;
        {line_sync, frame_sync} <= sy;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (taken !== 1'b1 && n < 100);
        cmp_bit(taken, 1'b1);
    endtask
    // ------------------------------------------------------------
    // scoreboard: words enter on take, pixels leave on strobe
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (taken === 1'b1)
            q.push_back({eight_bit, line_sync, frame_sync, de, red, green,
                         blue});
        if (rx_de === 1'b1)
        begin
            while (q.size() > 0 && !q[0][24])
                void'(q.pop_front());
            if (q.size() == 0)
                cmp_bit(rx_de, 1'b0);
            else
            begin
                exp_word = q.pop_front();
                cmp_byte(rx_red, exp_colour(exp_word[23:16], exp_word[27]));
                cmp_byte(rx_green, exp_colour(exp_word[15:8], exp_word[27]));
                cmp_byte(rx_blue, exp_colour(exp_word[7:0], exp_word[27]));
                cmp_byte({6'h00, rx_hs, rx_vs}, {6'h00, exp_word[26:25]});
            end
        end
    end
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #1000000;
        miscompares++;
        conclude();
    end
    initial
    begin
        seed = 83;
        {rst_b, eight_bit, scan_sel, line_sync, frame_sync, de} = 6'h00;
        {red, green, blue} = 24'h000000;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            // quiet words drain the link before the modes move
            repeat (3) send(24'h000000, 1'b0, 2'h0);
            eight_bit <= m[0];
            scan_sel <= m[1];
            repeat (4) @(posedge ref_clk);
            cmp_bit(rx_eight, m[0]);
            cmp_bit(rx_rev, m[1]);
            send(24'hffffff, 1'b1, 2'h3);
            send(24'h80c1a5, 1'b1, 2'h1);
            send(24'h5a3c7e, 1'b0, 2'h2);
            repeat (30)
            begin
                rnd = $random(seed);
                send(rnd[23:0], rnd[24], rnd[26:25]);
            end
        end
        repeat (3) send(24'h000000, 1'b0, 2'h0);
        repeat (100) @(posedge ref_clk);
        foreach (q[i]) cmp_bit(q[i][24], 1'b0);
        conclude();
    end
endmodule // lvds_panel_pixel_input_bench
